// ===== verilog/afic_pkg.sv
// Constants, field layout and carrier types of the activity, filter and interrupt-map register group.
package afic_pkg;

   // Register offsets on the serial register port.
   localparam logic [7:0] ADDR_LEVEL_HIGH  = 8'h25;
   localparam logic [7:0] ADDR_LEVEL_LOW   = 8'h26;
   localparam logic [7:0] ADDR_RUN_LENGTH  = 8'h27;
   localparam logic [7:0] ADDR_FILTER      = 8'h28;
   localparam logic [7:0] ADDR_WATERMARK   = 8'h29;
   localparam logic [7:0] ADDR_PIN_ROUTING = 8'h2A;

   // Reset values.
   localparam logic [7:0] RST_LEVEL_HIGH  = 8'h00;
   localparam logic [7:0] RST_LEVEL_LOW   = 8'h00;
   localparam logic [7:0] RST_RUN_LENGTH  = 8'h01;
   localparam logic [7:0] RST_FILTER      = 8'h00;
   localparam logic [7:0] RST_WATERMARK   = 8'h60;
   localparam logic [7:0] RST_PIN_ROUTING = 8'h00;

   // Writable bits; reserved bit 7 of these two registers reads as zero.
   localparam logic [7:0] FILTER_WR_MASK    = 8'h7F;
   localparam logic [7:0] WATERMARK_WR_MASK = 8'h7F;

   // Field positions.
   localparam int HP_LSB       = 4;
   localparam int HP_MSB       = 6;
   localparam int RATE_LSB     = 0;
   localparam int RATE_MSB     = 3;
   localparam int WM_MSB       = 6;
   localparam int MAP_ONE_LSB  = 0;
   localparam int MAP_ONE_MSB  = 3;
   localparam int MAP_TWO_LSB  = 4;
   localparam int MAP_TWO_MSB  = 7;

   // Sample and threshold alignment.
   localparam int SAMPLE_W  = 20;
   localparam int LIMIT_W   = 16;
   localparam int LIMIT_LSB = 3;

   // Filter decode.
   localparam logic [2:0]  HP_BYPASS_CODE = 3'h0;
   localparam logic [2:0]  HP_LAST_CODE   = 3'h6;
   localparam logic [3:0]  RATE_LAST_CODE = 4'hA;
   localparam logic [21:0] RATE_TOP_MHZ   = 22'h3D0900;
   localparam int          LOWPASS_SHIFT  = 2;

   // High-pass corner as a fraction of the output rate, in units of 1e-8.
   localparam logic [6:0][17:0] HP_RATIO_E8 = {
      18'h000EE, 18'h003BA, 18'h00F16, 18'h03CB9, 18'h0F284, 18'h3C4D8, 18'h00000};

   // Register access request from the serial front end.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } afic_reg_req_t;

   // Event vector; bit order matches each half of the routing register.
   typedef struct packed {
      logic activity;
      logic overrun;
      logic watermark;
      logic ready;
   } afic_events_t;

endpackage

// ===== verilog/afic_axis_compare.sv
// Magnitude comparison of one axis sample against the aligned activity level.
`timescale 1ns/1ps
module afic_axis_compare #(
   parameter int SAMPLE_W  = 20,
   parameter int LIMIT_W   = 16,
   parameter int LIMIT_LSB = 3
) (
   // Sample and setting
   input  wire logic signed [SAMPLE_W-1:0] sample,
   input  wire logic                       enable,
   input  wire logic        [LIMIT_W-1:0]  limit,
   // Result
   output logic                            above
);

   logic [SAMPLE_W-1:0] mag;

   always_comb begin
      // [RULE17] absolute sample value
      // Negating the most negative sample leaves its bit pattern, which as unsigned is still right.
      mag = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : SAMPLE_W'(sample);
      // [RULE3] bit alignment, strictly greater
      // The top magnitude bit is kept so that a full-scale negative sample still counts as above.
      above = enable && (mag[SAMPLE_W-1:LIMIT_LSB] > {1'b0, limit});
   end

endmodule

// ===== verilog/afic_config.sv
// Activity detector, filter settings, watermark and interrupt-pin routing registers.
`timescale 1ns/1ps
// What this block does
// [RULE1] Activity level split high then low byte
// [RULE2] Level is an unsigned magnitude
// [RULE3] Level bits align with sample bits 18:3
// [RULE4] Count only when strictly above level
// [RULE5] Activity after run length; resets to 1
// [RULE6] High-pass corner zero bypasses the filter
// [RULE7] Codes 1 to 6 set fixed corner fractions
// [RULE8] Rate code halves rate and low-pass corner
// [RULE9] Watermark raised when fill reaches the setting; the code never raises it while the setting is zero
// [RULE10] Watermark setting resets to 96
// [RULE11] Mapped events combine onto each pin
// [RULE12] Upper routing bits feed pin two
// [RULE13] Lower routing bits feed pin one
// [RULE14] Only selected axes take part
// [RULE15] Polarity bit selects pin active level
// [RULE16] Miss clears count; reserved bits read zero
// [RULE17] Compare absolute values once per sample
module afic_config #(
   parameter int RUN_W = 8
) (
   // Clock, reset and enable
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   input  wire logic                                 ce,
   // Register port
   input  wire afic_pkg::afic_reg_req_t              reg_req,
   output logic [7:0]                                reg_rdata,
   output logic                                      reg_rvalid,
   // Samples
   input  wire logic                                 sample_valid,
   input  wire logic signed [afic_pkg::SAMPLE_W-1:0] x_axis_sample,
   input  wire logic signed [afic_pkg::SAMPLE_W-1:0] y_axis_sample,
   input  wire logic signed [afic_pkg::SAMPLE_W-1:0] z_axis_sample,
   // Settings held elsewhere
   input  wire logic [2:0]                           activity_axis_select,
   input  wire logic                                 irq_polarity_select,
   // Queue status
   input  wire logic [6:0]                           queue_fill_level,
   input  wire logic                                 queue_overrun_event,
   input  wire logic                                 data_ready_event,
   // Detector and watermark state
   output logic                                      activity_detected,
   output logic                                      watermark_reached,
   output logic [afic_pkg::LIMIT_W-1:0]              activity_level_limit,
   // Filter settings
   output logic [2:0]                                highpass_corner_select,
   output logic                                      highpass_bypass,
   output logic [17:0]                               highpass_ratio_e8,
   output logic [3:0]                                rate_lowpass_select,
   output logic [21:0]                               output_rate_mhz,
   output logic [21:0]                               lowpass_corner_mhz,
   // Interrupt pins
   output logic                                      irq_pin_one,
   output logic                                      irq_pin_two
);

   logic [7:0]       activity_level_high;
   logic [7:0]       activity_level_low;
   logic [7:0]       activity_run_length;
   logic [7:0]       filter_settings;
   logic [7:0]       queue_watermark;
   logic [7:0]       irq_pin_routing;
   logic [7:0]       next_level_high;
   logic [7:0]       next_level_low;
   logic [7:0]       next_run_length;
   logic [7:0]       next_filter;
   logic [7:0]       next_watermark;
   logic [7:0]       next_routing;
   logic [7:0]       next_rdata;
   logic             next_rvalid;
   logic [RUN_W-1:0] run_count;
   logic [RUN_W-1:0] next_run_count;
   logic [RUN_W-1:0] run_needed;
   logic             next_activity;
   logic             next_watermark_hit;
   logic [2:0]       axis_above;
   logic             any_above;
   logic             next_bypass;
   logic [17:0]      next_ratio;
   logic [3:0]       rate_code;
   logic [21:0]      next_rate;
   logic             next_pin_one;
   logic             next_pin_two;
   logic             level_one;
   logic             level_two;
   afic_pkg::afic_events_t events;

   logic signed [afic_pkg::SAMPLE_W-1:0] axis_sample [3];

   assign axis_sample[0] = x_axis_sample;
   assign axis_sample[1] = y_axis_sample;
   assign axis_sample[2] = z_axis_sample;

   // [RULE14] per-axis enable
   // [RULE3] sample bit alignment
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_axis
         afic_axis_compare #(
            .SAMPLE_W  (afic_pkg::SAMPLE_W),
            .LIMIT_W   (afic_pkg::LIMIT_W),
            .LIMIT_LSB (afic_pkg::LIMIT_LSB)
         ) u_cmp (
            .sample (axis_sample[g]),
            .enable (activity_axis_select[g]),
            .limit  (activity_level_limit),
            .above  (axis_above[g])
         );
      end
   endgenerate

   assign any_above = |axis_above;

   // [RULE1] level assembly
   // [RULE2] unsigned level
   assign activity_level_limit = {activity_level_high, activity_level_low};

   // Register writes and reads.
   always_comb begin
      next_level_high = activity_level_high;
      next_level_low  = activity_level_low;
      next_run_length = activity_run_length;
      next_filter     = filter_settings;
      next_watermark  = queue_watermark;
      next_routing    = irq_pin_routing;
      next_rdata      = 8'h00;
      next_rvalid     = reg_req.rd;
      if (reg_req.wr) begin
         // [RULE16] reserved bits masked
         case (reg_req.addr)
            afic_pkg::ADDR_LEVEL_HIGH:  next_level_high = reg_req.wdata;
            afic_pkg::ADDR_LEVEL_LOW:   next_level_low  = reg_req.wdata;
            afic_pkg::ADDR_RUN_LENGTH:  next_run_length = reg_req.wdata;
            afic_pkg::ADDR_FILTER:      next_filter     = reg_req.wdata & afic_pkg::FILTER_WR_MASK;
            afic_pkg::ADDR_WATERMARK:   next_watermark  = reg_req.wdata & afic_pkg::WATERMARK_WR_MASK;
            afic_pkg::ADDR_PIN_ROUTING: next_routing    = reg_req.wdata;
            default:                    next_rdata      = 8'h00;
         endcase
      end
      // Unmapped offsets read as zero so the serial port never returns stale data.
      case (reg_req.addr)
         afic_pkg::ADDR_LEVEL_HIGH:  next_rdata = activity_level_high;
         afic_pkg::ADDR_LEVEL_LOW:   next_rdata = activity_level_low;
         afic_pkg::ADDR_RUN_LENGTH:  next_rdata = activity_run_length;
         afic_pkg::ADDR_FILTER:      next_rdata = filter_settings;
         afic_pkg::ADDR_WATERMARK:   next_rdata = queue_watermark;
         afic_pkg::ADDR_PIN_ROUTING: next_rdata = irq_pin_routing;
         default:                    next_rdata = 8'h00;
      endcase
      if (!reg_req.rd) begin
         next_rdata = reg_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // [RULE10] watermark reset value
         activity_level_high <= afic_pkg::RST_LEVEL_HIGH;
         activity_level_low  <= afic_pkg::RST_LEVEL_LOW;
         activity_run_length <= afic_pkg::RST_RUN_LENGTH;
         filter_settings     <= afic_pkg::RST_FILTER;
         queue_watermark     <= afic_pkg::RST_WATERMARK;
         irq_pin_routing     <= afic_pkg::RST_PIN_ROUTING;
         reg_rdata           <= 8'h00;
         reg_rvalid          <= 1'b0;
      end else if (ce) begin
         activity_level_high <= next_level_high;
         activity_level_low  <= next_level_low;
         activity_run_length <= next_run_length;
         filter_settings     <= next_filter;
         queue_watermark     <= next_watermark;
         irq_pin_routing     <= next_routing;
         reg_rdata           <= next_rdata;
         reg_rvalid          <= next_rvalid;
      end
   end

   // Activity detector and watermark.
   always_comb begin
      // A run length of zero acts as one, so activity still needs one sample above the level after the count is cleared.
      run_needed     = (activity_run_length == 8'h00) ? RUN_W'(1) : RUN_W'(activity_run_length);
      next_run_count = run_count;
      next_activity  = activity_detected;
      // [RULE17] once per sample
      if (sample_valid) begin
         if (any_above) begin
            // [RULE4] count strictly above
            // The counter saturates so that long activity cannot wrap back below the run length.
            if (run_count != {RUN_W{1'b1}}) begin
               next_run_count = run_count + RUN_W'(1);
            end
            // [RULE5] declare after run length
            next_activity = (next_run_count >= run_needed);
         end else begin
            // [RULE16] miss clears the count
            next_run_count = '0;
            next_activity  = 1'b0;
         end
      end
      // [RULE9] watermark reached
      next_watermark_hit = (queue_watermark[afic_pkg::WM_MSB:0] != 7'h00) &&
                           (queue_fill_level >= queue_watermark[afic_pkg::WM_MSB:0]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         run_count         <= '0;
         activity_detected <= 1'b0;
         watermark_reached <= 1'b0;
      end else if (ce) begin
         run_count         <= next_run_count;
         activity_detected <= next_activity;
         watermark_reached <= next_watermark_hit;
      end
   end

   // Filter decode and interrupt pins.
   always_comb begin
      // [RULE6] zero corner bypasses
      // Code 7 has no corner defined, so it also leaves the filter out.
      next_bypass = (filter_settings[afic_pkg::HP_MSB:afic_pkg::HP_LSB] == afic_pkg::HP_BYPASS_CODE) ||
                    (filter_settings[afic_pkg::HP_MSB:afic_pkg::HP_LSB] > afic_pkg::HP_LAST_CODE);
      // [RULE7] corner fraction table
      next_ratio = next_bypass ? 18'h00000 :
                   afic_pkg::HP_RATIO_E8[filter_settings[afic_pkg::HP_MSB:afic_pkg::HP_LSB]];
      // [RULE8] halving rate decode
      rate_code = filter_settings[afic_pkg::RATE_MSB:afic_pkg::RATE_LSB];
      if (rate_code > afic_pkg::RATE_LAST_CODE) begin
         rate_code = afic_pkg::RATE_LAST_CODE;
      end
      next_rate = afic_pkg::RATE_TOP_MHZ >> rate_code;
      events.activity  = activity_detected;
      events.overrun   = queue_overrun_event;
      events.watermark = watermark_reached;
      events.ready     = data_ready_event;
      // [RULE11] events combine per pin
      // [RULE13] lower bits to pin one
      level_one = |(events & irq_pin_routing[afic_pkg::MAP_ONE_MSB:afic_pkg::MAP_ONE_LSB]);
      // [RULE12] upper bits to pin two
      level_two = |(events & irq_pin_routing[afic_pkg::MAP_TWO_MSB:afic_pkg::MAP_TWO_LSB]);
      // [RULE15] pin polarity
      next_pin_one = irq_polarity_select ? level_one : ~level_one;
      next_pin_two = irq_polarity_select ? level_two : ~level_two;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         highpass_corner_select <= 3'h0;
         highpass_bypass        <= 1'b1;
         highpass_ratio_e8      <= 18'h00000;
         rate_lowpass_select    <= 4'h0;
         output_rate_mhz        <= afic_pkg::RATE_TOP_MHZ;
         lowpass_corner_mhz     <= afic_pkg::RATE_TOP_MHZ >> afic_pkg::LOWPASS_SHIFT;
         irq_pin_one            <= 1'b1;
         irq_pin_two            <= 1'b1;
      end else if (ce) begin
         highpass_corner_select <= filter_settings[afic_pkg::HP_MSB:afic_pkg::HP_LSB];
         highpass_bypass        <= next_bypass;
         highpass_ratio_e8      <= next_ratio;
         rate_lowpass_select    <= filter_settings[afic_pkg::RATE_MSB:afic_pkg::RATE_LSB];
         output_rate_mhz        <= next_rate;
         lowpass_corner_mhz     <= next_rate >> afic_pkg::LOWPASS_SHIFT;
         irq_pin_one            <= next_pin_one;
         irq_pin_two            <= next_pin_two;
      end
   end

   // Checks on the block's own outputs and state.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_high_write;
      ce && reg_req.wr && (reg_req.addr == afic_pkg::ADDR_LEVEL_HIGH);
   endsequence

   sequence s_miss_sample;
      ce && sample_valid && !any_above;
   endsequence

   chk_level_high_write: assert property (s_high_write |=> activity_level_limit[15:8] == $past(reg_req.wdata)) // [RULE1]
      else $error("High level byte not stored.");

   chk_miss_clears_count: assert property (s_miss_sample |=> (run_count == '0) && !activity_detected) // [RULE16]
      else $error("Count not cleared on a miss.");

   chk_equal_not_counted: assert property ( // [RULE4]
      ce && sample_valid && activity_axis_select[0] &&
      (x_axis_sample[afic_pkg::SAMPLE_W-1:afic_pkg::LIMIT_LSB] == {1'b0, activity_level_limit}) &&
      (activity_axis_select[2:1] == 2'b00) |=> run_count == '0)
      else $error("Equal magnitude counted.");

   chk_activity_needs_run: assert property ($rose(activity_detected) |-> run_count >= run_needed) // [RULE5]
      else $error("Activity before run length.");

   chk_axes_masked: assert property (ce && sample_valid && (activity_axis_select == 3'h0) |=> run_count == '0) // [RULE14]
      else $error("Unselected axis counted.");

   chk_bypass_zero: assert property (ce && reg_req.wr && (reg_req.addr == afic_pkg::ADDR_FILTER) && // [RULE6]
      (reg_req.wdata[afic_pkg::HP_MSB:afic_pkg::HP_LSB] == 3'h0) ##1 ce |=> highpass_bypass)
      else $error("Zero corner not bypassed.");

   chk_lowpass_quarter: assert property ((lowpass_corner_mhz == (output_rate_mhz >> afic_pkg::LOWPASS_SHIFT)) && // [RULE8]
      ((rate_lowpass_select > afic_pkg::RATE_LAST_CODE) ||
       (output_rate_mhz == (afic_pkg::RATE_TOP_MHZ >> rate_lowpass_select))))
      else $error("Rate or low-pass corner does not follow the code.");

   chk_watermark_raise: assert property (ce && (queue_watermark[6:0] != 7'h00) && // [RULE9]
      (queue_fill_level >= queue_watermark[6:0]) |=> watermark_reached)
      else $error("Watermark not raised.");

   chk_watermark_reset: assert property ($fell(rst) |-> queue_watermark == afic_pkg::RST_WATERMARK) // [RULE10]
      else $error("Watermark reset value wrong.");

   chk_pin_one_route: assert property (ce && |(events & irq_pin_routing[3:0]) |=> // [RULE13]
      irq_pin_one == $past(irq_polarity_select))
      else $error("Pin one not asserted.");

   chk_pin_two_route: assert property (ce && !(|(events & irq_pin_routing[7:4])) |=> // [RULE12]
      irq_pin_two == !$past(irq_polarity_select))
      else $error("Pin two asserted without event.");

endmodule

// ===== bench/afic_host_model.sv
// Host processor model that issues requests on the register port.
`timescale 1ns/1ps
module afic_host_model (
   // Clock
   input  wire logic               clk,
   // Register port
   output afic_pkg::afic_reg_req_t reg_req,
   input  wire logic [7:0]         reg_rdata,
   input  wire logic               reg_rvalid
);
   initial begin
      reg_req = '0;
   end
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Idle fields show the inverse of the last request, so stale values are never mistaken for live ones.
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      reg_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
      tick();
      reg_req = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
      repeat (1 + $urandom_range(2)) tick();
   endtask
   task automatic read(input logic [7:0] addr, output logic [7:0] data, output bit ok);
      int n;
      reg_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'hA5};
      tick();
      reg_req = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      ok = (reg_rvalid === 1'b1);
      data = reg_rdata;
      repeat (1 + $urandom_range(2)) tick();
   endtask
endmodule

// ===== bench/test_activity_filter_irq_config.sv
// Self-checking bench for the activity, filter and pin routing register group.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_activity_filter_irq_config;
   logic                          clk = 1'b0;
   logic                          rst = 1'b1;
   logic                          ce = 1'b1;
   afic_pkg::afic_reg_req_t       reg_req;
   logic [7:0]                    reg_rdata;
   logic                          reg_rvalid;
   logic                          sample_valid = 1'b0;
   logic signed [19:0]            xs = '0, ys = '0, zs = '0;
   logic [2:0]                    activity_axis_select = '0;
   logic                          pol = 1'b0, ovr = 1'b0, rdy = 1'b0;
   logic [6:0]                    fill = '0;
   logic                          activity_detected, watermark_reached, highpass_bypass, irq_pin_one, irq_pin_two;
   logic [15:0]                   lim_out;
   logic [2:0]                    hp_sel;
   logic [17:0]                   hp_ratio;
   logic [3:0]                    rate_sel;
   logic [21:0]                   rate_mhz, lp_mhz;
   int                            bad_count = 0;
   int                            samples_checked = 0;
   int                            mreg [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h60, 8'h00};
   int                            hpr [8] = '{0, 247000, 62084, 15545, 3862, 954, 238, 0};
   int                            mcnt = 0;
   bit                            mact = 1'b0;
   always #12.5 clk = ~clk;
   afic_config i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .sample_valid(sample_valid), .x_axis_sample(xs), .y_axis_sample(ys),
      .z_axis_sample(zs), .activity_axis_select(activity_axis_select), .irq_polarity_select(pol),
      .queue_fill_level(fill), .queue_overrun_event(ovr), .data_ready_event(rdy),
      .activity_detected(activity_detected), .watermark_reached(watermark_reached),
      .activity_level_limit(lim_out), .highpass_corner_select(hp_sel), .highpass_bypass(highpass_bypass),
      .highpass_ratio_e8(hp_ratio), .rate_lowpass_select(rate_sel), .output_rate_mhz(rate_mhz),
      .lowpass_corner_mhz(lp_mhz), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
   afic_host_model i_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic reg_write(int a, int d);
      i_host.write(8'(a), 8'(d));
      if (a >= 8'h25 && a <= 8'h2A) begin
         mreg[a - 8'h25] = d & ((a == 8'h28 || a == 8'h29) ? 8'h7F : 8'hFF);
      end
   endtask
   task automatic reg_check(int a);
      logic [7:0] d;
      bit ok;
      i_host.read(8'(a), d, ok);
      if (!ok) begin
         bad_count++;
         end_sim();
      end else begin
         `CHK(d, 8'((a >= 8'h25 && a <= 8'h2A) ? mreg[a - 8'h25] : 0))
      end
   endtask
   // Drives one cycle of samples, advances the model and compares after the edge.
   task automatic step(bit v, int x, int y, int z, logic [2:0] sel);
      int s [3];
      bit hit;
      int lim;
      s = '{x, y, z};
      lim = mreg[0] * 256 + mreg[1];
      hit = 1'b0;
      xs = 20'(x);
      ys = 20'(y);
      zs = 20'(z);
      sample_valid = v;
      activity_axis_select = sel;
      for (int i = 0; i < 3; i++) begin
         if (sel[i] && ((s[i] < 0 ? -s[i] : s[i]) >> 3) > lim) begin
            hit = 1'b1;
         end
      end
      if (v) begin
         mcnt = hit ? (mcnt < 255 ? mcnt + 1 : 255) : 0;
         mact = mcnt >= ((mreg[2] == 0) ? 1 : mreg[2]);
      end
      tick();
      `CHK(activity_detected, mact)
   endtask
   function automatic int rand_sample(int lim);
      int m;
      m = lim * 8 + int'($urandom_range(23)) - 8;
      m = (m < 0) ? 0 : ((m > 524287) ? 524287 : m);
      return $urandom_range(1) ? -m : m;
   endfunction
   initial begin
      int lim;
      int wexp;
      logic [3:0] ev;
      void'($urandom(37));
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      tick();
      `CHK({irq_pin_one, irq_pin_two, activity_detected, watermark_reached}, 4'hC)
      for (int a = 8'h24; a <= 8'h2B; a++) reg_check(a);
      for (int a = 8'h24; a <= 8'h2B; a++) reg_write(a, $urandom_range(255));
      for (int a = 8'h2B; a >= 8'h24; a--) reg_check(a);
      ce = 1'b0;
      i_host.write(8'h26, 8'(~mreg[1]));
      ce = 1'b1;
      reg_check(8'h26);
      for (int r = 0; r < 16; r++) begin
         reg_write(8'h28, ($urandom_range(1) << 7) | ((r % 8) << 4) | r);
         `CHK(hp_sel, 3'(r % 8))
         `CHK(highpass_bypass, 1'((r % 8) == 0 || (r % 8) == 7))
         `CHK(hp_ratio, 18'(hpr[r % 8]))
         `CHK(rate_sel, 4'(r))
         `CHK(rate_mhz, 22'(4000000 >> (r > 10 ? 10 : r)))
         `CHK(lp_mhz, 22'(4000000 >> ((r > 10 ? 10 : r) + 2)))
         reg_check(8'h28);
      end
      for (int p = 0; p < 3; p++) begin
         lim = (p == 0) ? 16'h0010 : ((p == 1) ? $urandom_range(16'h0FFF) : 16'hFFFF);
         reg_write(8'h25, lim >> 8);
         reg_write(8'h26, lim & 8'hFF);
         reg_write(8'h27, (p == 0) ? 2 : $urandom_range(4));
         `CHK(lim_out, 16'(lim))
         for (int i = 0; i < 60; i++) begin
            step($urandom_range(3) != 0, (i % 10 == 9) ? -524288 : rand_sample(lim), rand_sample(lim),
               rand_sample(lim), 3'($urandom_range(7)));
         end
         step(1'b0, 0, 0, 0, 3'h7);
      end
      rst = 1'b1;
      tick();
      rst = 1'b0;
      mreg = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h60, 8'h00};
      mcnt = 0;
      mact = 1'b0;
      `CHK({activity_detected, highpass_bypass, rate_mhz}, {1'b0, 1'b1, 22'h3D0900})
      for (int a = 8'h25; a <= 8'h2A; a++) reg_check(a);
      reg_write(8'h25, 0);
      reg_write(8'h26, 8'h10);
      reg_write(8'h27, 1);
      for (int i = 0; i < 40; i++) begin
         reg_write(8'h29, $urandom_range(127));
         reg_write(8'h2A, $urandom_range(255));
         wexp = mreg[4] + int'($urandom_range(4)) - 2;
         fill = 7'((wexp < 0) ? 0 : ((wexp > 127) ? 127 : wexp));
         pol = 1'($urandom_range(1));
         ovr = 1'($urandom_range(1));
         rdy = 1'($urandom_range(1));
         step(1'b1, $urandom_range(1) ? 4000 : 0, 0, 0, 3'h1);
         sample_valid = 1'b0;
         tick();
         wexp = (mreg[4] != 0 && fill >= mreg[4]);
         ev = {mact, ovr, 1'(wexp), rdy};
         `CHK(watermark_reached, 1'(wexp))
         `CHK(irq_pin_one, pol ? |(ev & 4'(mreg[5])) : ~|(ev & 4'(mreg[5])))
         `CHK(irq_pin_two, pol ? |(ev & 4'(mreg[5] >> 4)) : ~|(ev & 4'(mreg[5] >> 4)))
      end
      end_sim();
   end
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule
